// >>> verilog/spl_servo_map.svh
// Purpose: constants of the servo pid loop: rates, default gains, limits
// Assumes: fixed point values are signed Q16.16 in 32 bits
// Notes: degrees for angles, rpm for velocity, current-reference bits for effort
`ifndef SPL_SERVO_MAP_SVH
`define SPL_SERVO_MAP_SVH

`define SPL_CLK_HZ 100000000
`define SPL_SAMPLE_RATE_HZ 6500
`define SPL_PWM_HZ 187500
`define SPL_FILTER_CUTOFF_HZ 1000
`define SPL_RPM_SCALE 0.166666667
`define SPL_Q_FRAC 16
`define SPL_Q_ONE 32'h0001_0000
`define SPL_DEG_180 32'h00B4_0000
`define SPL_DEG_360 32'h0168_0000
`define SPL_VEL_ILIMIT 32'h00C8_0000
`define SPL_EFFORT_LIMIT 255
`define SPL_STEP_SIZE 32'h0000_1CCD

// power-up gains, Q16.16
`define SPL_RST_POS_PROP 32'h000A_0000
`define SPL_RST_POS_INT 32'h0000_0000
`define SPL_RST_POS_DERIV 32'h0014_0000
`define SPL_RST_VEL_PROP 32'h0000_0CCD
`define SPL_RST_VEL_INT 32'h0000_086F
`define SPL_RST_VEL_DERIV 32'h0003_0000

`endif

// >>> verilog/spl_servo_pkg.sv
// Purpose: types of the servo pid loop
// Assumes: constants live in spl_servo_map.svh
// Notes: modes and states are one-hot
`default_nettype none
package spl_servo_pkg;

   typedef logic signed [31:0] spl_q_t;

   typedef enum logic [2:0] {
      SPL_MODE_POSITION = 3'b001,
      SPL_MODE_VELOCITY = 3'b010,
      SPL_MODE_TORQUE = 3'b100
   } spl_mode_t;

   typedef enum logic [2:0] {
      SPL_GSEL_POS_PROP = 3'h0,
      SPL_GSEL_POS_INT = 3'h1,
      SPL_GSEL_POS_DERIV = 3'h2,
      SPL_GSEL_VEL_PROP = 3'h3,
      SPL_GSEL_VEL_INT = 3'h4,
      SPL_GSEL_VEL_DERIV = 3'h5
   } spl_gsel_t;

   typedef enum logic [3:0] {
      SPL_ST_IDLE = 4'b0001,
      SPL_ST_UNWRAP = 4'b0010,
      SPL_ST_FILT = 4'b0100,
      SPL_ST_OUT = 4'b1000
   } spl_state_t;

   typedef struct packed {
      spl_q_t pos_prop_gain;
      spl_q_t pos_int_gain;
      spl_q_t pos_deriv_gain;
      spl_q_t vel_prop_gain;
      spl_q_t vel_int_gain;
      spl_q_t vel_deriv_gain;
   } spl_gains_t;

   typedef struct packed {
      logic wr;
      spl_gsel_t sel;
      spl_q_t data;
   } spl_gain_wr_t;

endpackage
`default_nettype wire

// >>> verilog/spl_servo_pid_loop.sv
// Purpose: sampled position / velocity / torque servo controller
// Assumes: angle_in is the corrected angle, Q16.16 degrees in [0,360)
// Notes: one update per sample tick; effort drives a sign plus pwm reference
//
// Overview of operation
// - after reset the gains take their default values
// - position effort sums proportional, accumulating integral and derivative terms
// - position derivative acts on negated unwrapped angle change, not on error
// - position derivative is low-pass filtered with pole exp(-2 pi fc Ts)
// - velocity estimate filters previous estimate and unwrapped angle change
// - velocity scaled by sample rate times 0.166666667 giving rpm
// - velocity error is setpoint plus stored negated velocity estimate
// - velocity integral adds gain times error, clamped to plus/minus 200
// - velocity effort is P plus integral minus D on error change
// - effort is signed and limited to plus/minus the effort limit
// - keep corrected angle and unwrapped angle counting whole turns
// - with step/dir enabled each step moves the setpoint, dir picks sign
// - current reference pwm runs at 187.5 kHz
`timescale 1ns/1ps
`default_nettype none
`include "spl_servo_map.svh"

module spl_servo_pid_loop #(
   parameter int CLK_HZ = `SPL_CLK_HZ,
   parameter int SAMPLE_RATE_HZ = `SPL_SAMPLE_RATE_HZ,
   parameter int TICK_COMPARE = (CLK_HZ + SAMPLE_RATE_HZ / 2) / SAMPLE_RATE_HZ,
   parameter int FILTER_CUTOFF_HZ = `SPL_FILTER_CUTOFF_HZ,
   parameter int EFFORT_LIMIT = `SPL_EFFORT_LIMIT,
   parameter logic signed [31:0] STEP_SIZE = `SPL_STEP_SIZE
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic loop_enable,
   input wire spl_servo_pkg::spl_mode_t mode,
   input wire logic setpoint_load,
   input wire spl_servo_pkg::spl_q_t setpoint_in,
   input wire logic step_dir_enable,
   input wire logic step_in,
   input wire logic dir_in,
   input wire spl_servo_pkg::spl_gain_wr_t gain_wr,
   input wire spl_servo_pkg::spl_q_t angle_in,
   output logic signed [15:0] effort,
   output logic pwm_out,
   output logic pwm_negative,
   output spl_servo_pkg::spl_q_t unwrapped_angle,
   output spl_servo_pkg::spl_q_t setpoint,
   output logic sample_done
);

   localparam int PWM_PERIOD = (CLK_HZ + `SPL_PWM_HZ / 2) / `SPL_PWM_HZ;
   localparam real SAMPLE_PERIOD_S = 1.0 / SAMPLE_RATE_HZ;
   localparam real POLE = $exp(-FILTER_CUTOFF_HZ * 2.0 * 3.14159265358979 * SAMPLE_PERIOD_S);
   localparam real QSCALE = 65536.0;
   // both filters share one cutoff, hence one pole value
   localparam logic signed [31:0] POS_FILTER_POLE = 32'(int'(POLE * QSCALE));
   localparam logic signed [31:0] POS_FILTER_GAIN = 32'(int'((1.0 - POLE) * QSCALE));
   localparam logic signed [31:0] VEL_FILTER_POLE = 32'(int'(POLE * QSCALE));
   localparam logic signed [31:0] VEL_FILTER_INPUT_COEF =
      32'(int'((1.0 - POLE) * SAMPLE_RATE_HZ * `SPL_RPM_SCALE * QSCALE));
   localparam logic signed [15:0] LIMIT = 16'(EFFORT_LIMIT);

   if (TICK_COMPARE < 8 || EFFORT_LIMIT < 1 || EFFORT_LIMIT >= PWM_PERIOD ||
       EFFORT_LIMIT > 32767) begin : g_bad_param
      $error("servo pid loop: unsupported parameter value");
   end

   // Q16.16 product with saturation-free truncation; callers keep ranges small
   function automatic spl_servo_pkg::spl_q_t qmul(input spl_servo_pkg::spl_q_t a,
                                                   input spl_servo_pkg::spl_q_t b);
      logic signed [63:0] p;
      p = 64'(a) * 64'(b);
      return p[47:16];
   endfunction

   // Q16.16 to whole current-reference bits, limited to the effort range
   function automatic logic signed [15:0] limit_effort(input spl_servo_pkg::spl_q_t q);
      logic signed [15:0] whole;
      whole = 16'(q >>> `SPL_Q_FRAC);
      if (q > (32'(LIMIT) <<< `SPL_Q_FRAC)) begin
         return LIMIT;
      end
      else if (q < -(32'(LIMIT) <<< `SPL_Q_FRAC)) begin
         return -LIMIT;
      end
      return whole;
   endfunction

   spl_servo_pkg::spl_state_t state;
   spl_servo_pkg::spl_gains_t gains;
   logic [31:0] tick_cnt;
   logic tick;
   logic step_prev;
   spl_servo_pkg::spl_q_t corrected_angle;
   spl_servo_pkg::spl_q_t prior_unwrapped_angle;
   spl_servo_pkg::spl_q_t angle_step;
   spl_servo_pkg::spl_q_t pos_iterm;
   spl_servo_pkg::spl_q_t pos_dterm;
   spl_servo_pkg::spl_q_t vel_neg;
   spl_servo_pkg::spl_q_t vel_iterm;
   spl_servo_pkg::spl_q_t prior_error;
   logic [15:0] pwm_cnt;
   logic [15:0] pwm_duty;

   spl_servo_pkg::spl_q_t next_angle_step;
   spl_servo_pkg::spl_q_t pos_error;
   spl_servo_pkg::spl_q_t vel_error;
   spl_servo_pkg::spl_q_t next_vel_iterm;
   spl_servo_pkg::spl_q_t next_effort_q;
   spl_servo_pkg::spl_q_t cur_error;

   // sample timer
   always_ff @(posedge clk) begin
      if (srst || tick_cnt == 32'(TICK_COMPARE - 1)) begin
         tick_cnt <= 32'h0000_0000;
      end
      else begin
         tick_cnt <= tick_cnt + 32'h0000_0001;
      end
      tick <= !srst && tick_cnt == 32'(TICK_COMPARE - 1);
   end

   // sample sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= spl_servo_pkg::SPL_ST_IDLE;
      end
      else begin
         case (state)
            spl_servo_pkg::SPL_ST_IDLE: begin
               if (tick) begin
                  state <= spl_servo_pkg::SPL_ST_UNWRAP;
               end
            end
            spl_servo_pkg::SPL_ST_UNWRAP: state <= spl_servo_pkg::SPL_ST_FILT;
            spl_servo_pkg::SPL_ST_FILT: state <= spl_servo_pkg::SPL_ST_OUT;
            spl_servo_pkg::SPL_ST_OUT: state <= spl_servo_pkg::SPL_ST_IDLE;
            default: state <= spl_servo_pkg::SPL_ST_IDLE;
         endcase
      end
   end

   // shortest move between samples; the angle may cross 0/360 either way
   always_comb begin
      next_angle_step = angle_in - corrected_angle;
      // map macros are unsigned literals; a mixed compare would go unsigned
      if (next_angle_step > $signed(`SPL_DEG_180)) begin
         next_angle_step = next_angle_step - `SPL_DEG_360;
      end
      else if (next_angle_step < -$signed(`SPL_DEG_180)) begin
         next_angle_step = next_angle_step + `SPL_DEG_360;
      end
   end

   // angle tracking runs even when the loop is off so enabling causes no jump
   always_ff @(posedge clk) begin
      if (srst) begin
         corrected_angle <= 32'h0000_0000;
         unwrapped_angle <= 32'h0000_0000;
         prior_unwrapped_angle <= 32'h0000_0000;
      end
      else if (state == spl_servo_pkg::SPL_ST_UNWRAP) begin
         corrected_angle <= angle_in;
         unwrapped_angle <= unwrapped_angle + next_angle_step;
      end
      else if (state == spl_servo_pkg::SPL_ST_OUT) begin
         prior_unwrapped_angle <= unwrapped_angle;
      end
   end

   // setpoint: loaded by host or moved by step pulses
   always_ff @(posedge clk) begin
      if (srst) begin
         setpoint <= 32'h0000_0000;
         step_prev <= 1'b0;
      end
      else begin
         step_prev <= step_in;
         if (step_dir_enable && step_in && !step_prev) begin
            setpoint <= dir_in ? setpoint - STEP_SIZE : setpoint + STEP_SIZE;
         end
         else if (setpoint_load) begin
            setpoint <= setpoint_in;
         end
      end
   end

   // gains, editable at run time; lost at reset
   always_ff @(posedge clk) begin
      if (srst) begin
         gains.pos_prop_gain <= `SPL_RST_POS_PROP;
         gains.pos_int_gain <= `SPL_RST_POS_INT;
         gains.pos_deriv_gain <= `SPL_RST_POS_DERIV;
         gains.vel_prop_gain <= `SPL_RST_VEL_PROP;
         gains.vel_int_gain <= `SPL_RST_VEL_INT;
         gains.vel_deriv_gain <= `SPL_RST_VEL_DERIV;
      end
      else if (gain_wr.wr) begin
         case (gain_wr.sel)
            spl_servo_pkg::SPL_GSEL_POS_PROP: gains.pos_prop_gain <= gain_wr.data;
            spl_servo_pkg::SPL_GSEL_POS_INT: gains.pos_int_gain <= gain_wr.data;
            spl_servo_pkg::SPL_GSEL_POS_DERIV: gains.pos_deriv_gain <= gain_wr.data;
            spl_servo_pkg::SPL_GSEL_VEL_PROP: gains.vel_prop_gain <= gain_wr.data;
            spl_servo_pkg::SPL_GSEL_VEL_INT: gains.vel_int_gain <= gain_wr.data;
            spl_servo_pkg::SPL_GSEL_VEL_DERIV: gains.vel_deriv_gain <= gain_wr.data;
            default: gains <= gains;
         endcase
      end
   end

   assign angle_step = unwrapped_angle - prior_unwrapped_angle;

   // error and effort of the current sample
   always_comb begin
      pos_error = setpoint - unwrapped_angle;
      vel_error = setpoint + vel_neg;
      next_vel_iterm = vel_iterm + qmul(gains.vel_int_gain, vel_error);
      if (next_vel_iterm > $signed(`SPL_VEL_ILIMIT)) begin
         next_vel_iterm = `SPL_VEL_ILIMIT;
      end
      else if (next_vel_iterm < -$signed(`SPL_VEL_ILIMIT)) begin
         next_vel_iterm = -`SPL_VEL_ILIMIT;
      end
      case (mode)
         spl_servo_pkg::SPL_MODE_POSITION: begin
            cur_error = pos_error;
            next_effort_q = qmul(gains.pos_prop_gain, pos_error) + pos_iterm + pos_dterm;
         end
         spl_servo_pkg::SPL_MODE_VELOCITY: begin
            cur_error = vel_error;
            next_effort_q = qmul(gains.vel_prop_gain, vel_error) + next_vel_iterm
                            - qmul(gains.vel_deriv_gain, vel_error - prior_error);
         end
         spl_servo_pkg::SPL_MODE_TORQUE: begin
            cur_error = 32'h0000_0000;
            next_effort_q = setpoint;
         end
         default: begin
            cur_error = 32'h0000_0000;
            next_effort_q = 32'h0000_0000;
         end
      endcase
   end

   // filter and integrator state; cleared while the loop is off against windup
   always_ff @(posedge clk) begin
      if (srst || !loop_enable) begin
         pos_iterm <= 32'h0000_0000;
         pos_dterm <= 32'h0000_0000;
         vel_neg <= 32'h0000_0000;
         vel_iterm <= 32'h0000_0000;
         prior_error <= 32'h0000_0000;
      end
      else if (state == spl_servo_pkg::SPL_ST_FILT) begin
         if (mode == spl_servo_pkg::SPL_MODE_POSITION) begin
            pos_iterm <= pos_iterm + qmul(gains.pos_int_gain, pos_error);
            pos_dterm <= qmul(POS_FILTER_POLE, pos_dterm)
                         - qmul(qmul(gains.pos_deriv_gain, POS_FILTER_GAIN), angle_step);
         end
         if (mode == spl_servo_pkg::SPL_MODE_VELOCITY) begin
            vel_neg <= -(qmul(VEL_FILTER_POLE, -vel_neg)
                         + qmul(VEL_FILTER_INPUT_COEF, angle_step));
         end
      end
      else if (state == spl_servo_pkg::SPL_ST_OUT) begin
         if (mode == spl_servo_pkg::SPL_MODE_VELOCITY) begin
            vel_iterm <= next_vel_iterm;
         end
         prior_error <= cur_error;
      end
   end

   // effort register, updated once per enabled sample
   always_ff @(posedge clk) begin
      if (srst || !loop_enable) begin
         effort <= 16'h0000;
         sample_done <= 1'b0;
      end
      else begin
         sample_done <= state == spl_servo_pkg::SPL_ST_OUT;
         if (state == spl_servo_pkg::SPL_ST_OUT) begin
            effort <= limit_effort(next_effort_q);
         end
      end
   end

   // fast pwm keeps the current reference ripple above the audible band
   always_ff @(posedge clk) begin
      if (srst) begin
         pwm_cnt <= 16'h0000;
         pwm_duty <= 16'h0000;
         pwm_out <= 1'b0;
         pwm_negative <= 1'b0;
      end
      else begin
         if (pwm_cnt == 16'(PWM_PERIOD - 1)) begin
            pwm_cnt <= 16'h0000;
            pwm_duty <= effort[15] ? 16'(-effort) : 16'(effort);
            pwm_negative <= effort[15];
         end
         else begin
            pwm_cnt <= pwm_cnt + 16'h0001;
         end
         pwm_out <= pwm_cnt < pwm_duty;
      end
   end

endmodule // spl_servo_pid_loop
`default_nettype wire

// >>> testbench/spl_servo_pid_loop_props.sv
// Purpose: port assertions of the servo pid loop
// Assumes: tick compare of 9 clocks or more
// Notes: bound to every loop instance
`timescale 1ns/1ps
`default_nettype none
module spl_servo_pid_loop_props #(
   parameter int EFFORT_LIMIT = 255,
   parameter logic signed [31:0] STEP_SIZE = 32'sh0000_1CCD
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic loop_enable,
   input wire spl_servo_pkg::spl_mode_t mode,
   input wire logic setpoint_load,
   input wire spl_servo_pkg::spl_q_t setpoint_in,
   input wire logic step_dir_enable,
   input wire logic step_in,
   input wire logic dir_in,
   input wire spl_servo_pkg::spl_gain_wr_t gain_wr,
   input wire spl_servo_pkg::spl_q_t angle_in,
   input wire logic signed [15:0] effort,
   input wire logic pwm_out,
   input wire logic pwm_negative,
   input wire spl_servo_pkg::spl_q_t unwrapped_angle,
   input wire spl_servo_pkg::spl_q_t setpoint,
   input wire logic sample_done
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (srst);
   function automatic logic signed [15:0] lim(input logic signed [31:0] q);
      return (q >>> 16) > EFFORT_LIMIT ? 16'(EFFORT_LIMIT) :
         ((q >>> 16) < -EFFORT_LIMIT ? 16'(-EFFORT_LIMIT) : 16'(q >>> 16));
   endfunction
   property p_limit;
      effort <= EFFORT_LIMIT && effort >= -EFFORT_LIMIT;
   endproperty
   a_limit: assert property (p_limit) else $error("effort beyond limit");
   property p_off;
      !loop_enable && !$past(loop_enable) |-> effort == 16'sh0000 && !sample_done;
   endproperty
   a_off: assert property (p_off) else $error("disabled loop still drives");
   property p_done;
      sample_done |=> !sample_done [*8];
   endproperty
   a_done: assert property (p_done) else $error("sample pulses too close");
   property p_hold;
      loop_enable && $past(loop_enable) && $changed(effort) |-> sample_done;
   endproperty
   a_hold: assert property (p_hold) else $error("effort moved off sample");
   property p_step_up;
      step_dir_enable && step_in && !$past(step_in) && !dir_in
         |=> setpoint == $past(setpoint) + STEP_SIZE;
   endproperty
   a_step_up: assert property (p_step_up) else $error("step up wrong");
   property p_step_dn;
      step_dir_enable && step_in && !$past(step_in) && dir_in
         |=> setpoint == $past(setpoint) - STEP_SIZE;
   endproperty
   a_step_dn: assert property (p_step_dn) else $error("step down wrong");
   property p_torque;
      sample_done && $past(mode) == spl_servo_pkg::SPL_MODE_TORQUE
         |-> effort == lim($past(setpoint));
   endproperty
   a_torque: assert property (p_torque) else $error("torque effort wrong");
   property p_unwrap;
      unwrapped_angle - $past(unwrapped_angle) <= 32'sh00B4_0000 &&
         unwrapped_angle - $past(unwrapped_angle) >= -32'sh00B4_0000;
   endproperty
   a_unwrap: assert property (p_unwrap) else $error("unwrap jump too large");
   property p_load;
      setpoint_load && !(step_dir_enable && step_in && !$past(step_in))
         |=> setpoint == $past(setpoint_in);
   endproperty
   a_load: assert property (p_load) else $error("setpoint load lost");
   c_vel: cover property (sample_done && mode == spl_servo_pkg::SPL_MODE_VELOCITY);
   c_sat: cover property (effort == EFFORT_LIMIT);
   c_step: cover property (step_dir_enable && step_in && dir_in);
endmodule // spl_servo_pid_loop_props
bind spl_servo_pid_loop spl_servo_pid_loop_props #(.EFFORT_LIMIT(EFFORT_LIMIT),
   .STEP_SIZE(STEP_SIZE)) u_props (.clk(clk), .srst(srst), .loop_enable(loop_enable),
   .mode(mode), .setpoint_load(setpoint_load), .setpoint_in(setpoint_in),
   .step_dir_enable(step_dir_enable), .step_in(step_in), .dir_in(dir_in),
   .gain_wr(gain_wr), .angle_in(angle_in), .effort(effort), .pwm_out(pwm_out),
   .pwm_negative(pwm_negative), .unwrapped_angle(unwrapped_angle),
   .setpoint(setpoint), .sample_done(sample_done));
`default_nettype wire

// >>> testbench/spl_servo_enc_model.sv
// Purpose: shaft set to the bench target angle plus encoder seen by the loop
// Assumes: target given in whole degrees 0..359
// Notes: angle moves only right after a sample, never mid update
`timescale 1ns/1ps
`default_nettype none
module spl_servo_enc_model (
   input wire logic clk,
   input wire logic srst,
   input wire logic sample_done,
   input wire logic [8:0] target_deg,
   output spl_servo_pkg::spl_q_t angle_in
);
   always_ff @(posedge clk) begin
      if (srst) begin
         angle_in <= 32'sh0000_0000;
      end else if (sample_done) begin
         angle_in <= {7'h00, target_deg, 16'h0000};
      end
   end
endmodule // spl_servo_enc_model
`default_nettype wire

// >>> testbench/spl_servo_pid_loop_tb.sv
// Purpose: self-checking bench of the servo pid loop
// Assumes: short tick compare of 40 clocks
// Notes: derivative gains written to zero after the first position run so the model stays exact
`timescale 1ns/1ps
`default_nettype none
module spl_servo_pid_loop_tb;
   logic clk, srst, loop_enable, setpoint_load, step_dir_enable, step_in, dir_in;
   logic sample_done, pwm_out, pwm_negative;
   logic signed [15:0] effort;
   logic [8:0] target_deg;
   spl_servo_pkg::spl_mode_t mode;
   spl_servo_pkg::spl_q_t setpoint_in, angle_in, unwrapped_angle, setpoint;
   spl_servo_pkg::spl_gain_wr_t gain_wr;
   int failures, comparisons, seed, yw, shown, last, n, hi, pp, pi;
   longint sp, iacc, tot;
   longint n_sp [2] = '{64'sh0046_0000, -64'sh0046_0000};
   longint t_sp [5] = '{64'sh0064_8000, -64'sh8000, 64'sh012C_0000, -64'sh012C_0000, 0};
   spl_servo_pid_loop #(.TICK_COMPARE(40)) dut (.clk(clk), .srst(srst),
      .loop_enable(loop_enable), .mode(mode), .setpoint_load(setpoint_load),
      .setpoint_in(setpoint_in), .step_dir_enable(step_dir_enable), .step_in(step_in),
      .dir_in(dir_in), .gain_wr(gain_wr), .angle_in(angle_in), .effort(effort),
      .pwm_out(pwm_out), .pwm_negative(pwm_negative), .unwrapped_angle(unwrapped_angle),
      .setpoint(setpoint), .sample_done(sample_done));
   spl_servo_enc_model u_enc (.clk(clk), .srst(srst), .sample_done(sample_done),
      .target_deg(target_deg), .angle_in(angle_in));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function automatic longint lim(input longint v, input longint m);
      return v > m ? m : (v < -m ? -m : v);
   endfunction
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task automatic check(input string what, input logic signed [31:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %0d seen %0d", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (failures == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic load(input longint v);
      setpoint_in = 32'(v);
      setpoint_load = 1'b1;
      cyc(1);
      setpoint_load = 1'b0;
      sp = v;
   endtask
   // waits for one result and compares it with the integer model
   task automatic sample;
      int d;
      n = 0;
      while (sample_done !== 1'b1) begin
         cyc(1);
         n++;
         if (n > 200) begin
            failures++;
            complete_run();
         end
      end
      d = shown - last;
      if (d > 180) d -= 360;
      if (d < -180) d += 360;
      yw += d;
      last = shown;
      if (mode == spl_servo_pkg::SPL_MODE_VELOCITY) begin
         iacc = lim(iacc + sp, 200 * 65536);
         tot = sp + iacc;
      end else if (mode == spl_servo_pkg::SPL_MODE_POSITION) begin
         iacc += (sp - yw * 65536) * pi;
         tot = (sp - yw * 65536) * pp + iacc;
      end else begin
         tot = sp;
      end
      tot = lim(tot >>> 16, 255);
      check("effort", effort, 32'(tot));
      check("unwrapped_angle", unwrapped_angle, yw * 65536);
      shown = target_deg;
      cyc(1);
   endtask
   initial begin
      seed = 32'h34C0;
      {srst, loop_enable, setpoint_load, step_dir_enable, step_in, dir_in} = 6'h20;
      mode = spl_servo_pkg::SPL_MODE_POSITION;
      setpoint_in = 32'h0000_0000;
      gain_wr = '0;
      target_deg = 9'h000;
      {failures, comparisons, yw, shown, last} = '0;
      iacc = 0;
      repeat (6) @(posedge clk);
      #1;
      srst = 1'b0;
      pp = 10;
      pi = 0;
      load(64'sh0005_0000);
      loop_enable = 1'b1;
      sample();
      sample();
      loop_enable = 1'b0;
      cyc(2);
      check("effort_off", effort, 0);
      for (int i = 0; i < 6; i++) begin
         gain_wr = '{1'b1, spl_servo_pkg::spl_gsel_t'(i), (i % 3 == 2) ? 32'h0 : 32'h0001_0000};
         cyc(1);
         gain_wr.wr = 1'b0;
         cyc(1);
      end
      pp = 1;
      pi = 1;
      mode = spl_servo_pkg::SPL_MODE_VELOCITY;
      foreach (n_sp[j]) begin
         iacc = 0;
         load(n_sp[j]);
         loop_enable = 1'b1;
         repeat (5) sample();
         loop_enable = 1'b0;
         cyc(2);
      end
      iacc = 0;
      mode = spl_servo_pkg::SPL_MODE_POSITION;
      loop_enable = 1'b1;
      step_dir_enable = 1'b1;
      for (int i = 0; i < 10; i++) begin
         target_deg = 9'((shown + 360 + $random(seed) % 120) % 360);
         sample();
         dir_in = 1'($random(seed));
         step_in = 1'b1;
         cyc(1);
         step_in = 1'b0;
         sp += dir_in ? -64'sh1CCD : 64'sh1CCD;
         cyc(1);
         check("setpoint", setpoint, 32'(sp));
      end
      step_dir_enable = 1'b0;
      mode = spl_servo_pkg::SPL_MODE_TORQUE;
      foreach (t_sp[j]) begin
         sample();
         load(j == 4 ? longint'($random(seed)) >>> 7 : t_sp[j]);
         sample();
         cyc(1100);
         hi = 0;
         repeat (533) begin
            hi += int'(pwm_out === 1'b1);
            cyc(1);
         end
         check("pwm_duty", hi, 32'(tot < 0 ? -tot : tot));
         check("pwm_negative", pwm_negative, tot < 0);
      end
      complete_run();
   end
endmodule // spl_servo_pid_loop_tb
`default_nettype wire
